// [core/fmsp_consts.vh]
// Notes on behaviour
// - 8-bit async, filter on: flag needs stop
// - 9-bit, filter on: ninth bit 0 drops
// - bit 4 enables reception
// - bit 3 sent as ninth bit
// - ninth bit or stop latched to rx_ninth
// - tx flag: eighth bit or stop start
// - rx flag: eighth bit or mid stop
// - mode 0: shift register, clock on txd
// - mode 0: buffer write sends eight bits lsb-first
// - mode 0: receive when enabled, flag clear
// - 8-bit frame: start, eight data, stop
// - variable rate from either timer overflow
// - 8-bit async: stop loaded in ninth position
// - async receive starts on falling edge
// - 8-bit async: load only when flag clear
// - mode 2: clock over 64 or 32
// - 9-bit frame: eleven bits on line
// - 9-bit tx starts at next tick
// - 9-bit rx: load when flag clear, filter passes
// - mode 3: mode 2 with timer rate
// - async receive needs enable set
// - buffer write to tx, read from rx
// - sixteen overflow ticks per bit
// - mode 0 shift clock is core over 12
`ifndef FMSP_CONSTS_VH
`define FMSP_CONSTS_VH

// ****************************************
// register map
// ****************************************
`define FMSP_ADDR_CONTROL  8'h98
`define FMSP_ADDR_BUFFER   8'h99
`define FMSP_CONTROL_RESET 8'h00

// ****************************************
// control field positions
// ****************************************
`define FMSP_BIT_MODE_HIGH 7
`define FMSP_BIT_MODE_LOW  6
`define FMSP_BIT_FILTER    5
`define FMSP_BIT_RX_EN     4
`define FMSP_BIT_TX_NINTH  3
`define FMSP_BIT_RX_NINTH  2
`define FMSP_BIT_TX_DONE   1
`define FMSP_BIT_RX_DONE   0

// ****************************************
// timing counts
// ****************************************
`define FMSP_M0_DIV        12
`define FMSP_M0_HALF       6
`define FMSP_M2_DIV_SLOW   64
`define FMSP_M2_DIV_FAST   32
`define FMSP_TICKS_PER_BIT 16
`define FMSP_TICK_MID      7
`define FMSP_STOP_IDX_8    4'h9
`define FMSP_STOP_IDX_9    4'ha
`define FMSP_TX_FIFO_DEPTH 8

`endif

// [core/fmsp_fifo.v]
`timescale 1ns/100ps
module fmsp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             clk_sys,
    input  wire             rst_n,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;
    wire            push;
    wire            pop;

    assign in_ready  = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data  = mem_q[rd_ptr_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    function [AW-1:0] next_ptr;
        input [AW-1:0] p;
        begin
            next_ptr = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
        end
    endfunction

    always @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= next_ptr(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= next_ptr(rd_ptr_q);
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule

// [core/fmsp_serial_port.v]
`timescale 1ns/100ps
`include "fmsp_consts.vh"
module fmsp_serial_port #(
    parameter FIFO_DEPTH = `FMSP_TX_FIFO_DEPTH,
    parameter FIFO_AW    = 3
) (
    // clock and reset
    input  wire       clk_sys,
    input  wire       arst_n,
    // special function register port
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr_en,
    input  wire [7:0] sfr_wdata,
    input  wire       sfr_rd_en,
    output reg  [7:0] sfr_rdata,
    output wire       tx_fifo_ready,
    // rate sources
    input  wire       rate_doubler,
    input  wire       timer1_ovf,
    input  wire       timer2_ovf,
    input  wire       tx_use_timer2,
    input  wire       rx_use_timer2,
    // serial pins
    input  wire       rxd_in,
    output wire       rxd_out,
    output wire       rxd_oe_n,
    output wire       txd_out
);

    // ****************************************
    // reset and pin synchronisers
    // ****************************************
    reg  rst_meta_q;
    reg  rst_n_q;
    reg  rxd_meta_q;
    reg  rxd_s_q;
    reg  rxd_prev_q;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    always @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rxd_meta_q <= 1'b1;
            rxd_s_q    <= 1'b1;
            rxd_prev_q <= 1'b1;
        end else begin
            rxd_meta_q <= rxd_in;
            rxd_s_q    <= rxd_meta_q;
            rxd_prev_q <= rxd_s_q;
        end
    end

    // ****************************************
    // control register and fields
    // ****************************************
    reg  [7:0] ctrl_q;
    reg  [7:0] rx_buf_q;
    wire [1:0] mode;
    wire       filter_en;
    wire       rx_en;
    wire       wr_ctrl;
    wire       wr_buf;
    reg        ti_set;
    reg        ri_set;
    reg        rb8_load;
    reg        rb8_val;

    assign mode      = {ctrl_q[`FMSP_BIT_MODE_HIGH], ctrl_q[`FMSP_BIT_MODE_LOW]};
    assign filter_en = ctrl_q[`FMSP_BIT_FILTER];
    assign rx_en     = ctrl_q[`FMSP_BIT_RX_EN];
    assign wr_ctrl   = sfr_wr_en && (sfr_addr == `FMSP_ADDR_CONTROL);
    assign wr_buf    = sfr_wr_en && (sfr_addr == `FMSP_ADDR_BUFFER);

    // ****************************************
    // transmit fifo
    // ****************************************
    // writes land in the fifo; software must respect tx_fifo_ready
    wire       fifo_valid;
    reg        fifo_pop;
    wire [7:0] fifo_data;

    fmsp_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_tx_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n_q),
        .in_valid  (wr_buf),
        .in_ready  (tx_fifo_ready),
        .in_data   (sfr_wdata),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // ****************************************
    // rate generation
    // ****************************************
    reg  [3:0] m0_cnt_q;
    reg  [4:0] m2_cnt_q;
    reg        t1_half_q;
    wire       m2_tick;
    wire       t1_tick;
    wire       tx_tick;
    wire       rx_tick;
    wire       m0_end;

    // fixed mode ticks 16 per bit: every 4 or every 2 cycles
    assign m2_tick = rate_doubler ? (m2_cnt_q[0] == 1'b1)
                                  : (m2_cnt_q[1:0] == 2'b11);
    // the first timer is halved unless the doubler is set
    assign t1_tick = timer1_ovf & (rate_doubler | t1_half_q);
    assign tx_tick = (mode == 2'b10) ? m2_tick
                   : (tx_use_timer2 ? timer2_ovf : t1_tick);
    assign rx_tick = (mode == 2'b10) ? m2_tick
                   : (rx_use_timer2 ? timer2_ovf : t1_tick);
    assign m0_end  = (m0_cnt_q == (`FMSP_M0_DIV - 1));

    always @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            m2_cnt_q  <= 5'h00;
            t1_half_q <= 1'b0;
        end else begin
            m2_cnt_q <= m2_cnt_q + 5'h01;
            if (timer1_ovf) begin
                t1_half_q <= ~t1_half_q;
            end
        end
    end

    // ****************************************
    // transmit engine and mode 0 engine
    // ****************************************
    localparam S_IDLE  = 2'd0;
    localparam S_ASYNC = 2'd1;
    localparam S_M0TX  = 2'd2;
    localparam S_M0RX  = 2'd3;

    reg [1:0]  tx_st_q;
    reg [10:0] tx_sh_q;
    reg [3:0]  tx_bit_q;
    reg [3:0]  tx_sub_q;
    reg [7:0]  m0_rx_q;
    wire [3:0] stop_idx;

    assign stop_idx = mode[1] ? `FMSP_STOP_IDX_9 : `FMSP_STOP_IDX_8;
    assign txd_out  = (tx_st_q == S_M0TX || tx_st_q == S_M0RX)
                    ? (m0_cnt_q >= `FMSP_M0_HALF)
                    : (tx_st_q == S_ASYNC ? tx_sh_q[0] : 1'b1);
    assign rxd_out  = tx_sh_q[0];
    assign rxd_oe_n = (tx_st_q != S_M0TX);

    always @* begin
        fifo_pop = 1'b0;
        if (tx_st_q == S_IDLE && fifo_valid) begin
            fifo_pop = (mode == 2'b00) ? 1'b1 : tx_tick;
        end
    end

    always @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_st_q  <= S_IDLE;
            tx_sh_q  <= 11'h7ff;
            tx_bit_q <= 4'h0;
            tx_sub_q <= 4'h0;
            m0_cnt_q <= 4'h0;
            m0_rx_q  <= 8'h00;
        end else begin
            case (tx_st_q)
                S_IDLE: begin
                    tx_bit_q <= 4'h0;
                    tx_sub_q <= 4'h0;
                    m0_cnt_q <= 4'h0;
                    if (fifo_pop && mode == 2'b00) begin
                        tx_sh_q <= {3'b111, fifo_data};
                        tx_st_q <= S_M0TX;
                    end else if (fifo_pop) begin
                        // stop or ninth bit sits above the data
                        tx_sh_q <= {1'b1,
                                    mode[1] ? ctrl_q[`FMSP_BIT_TX_NINTH] : 1'b1,
                                    fifo_data, 1'b0};
                        tx_st_q <= S_ASYNC;
                    end else if (mode == 2'b00 && rx_en
                                 && !ctrl_q[`FMSP_BIT_RX_DONE]) begin
                        tx_st_q <= S_M0RX;
                    end
                end
                S_ASYNC: begin
                    if (tx_tick) begin
                        tx_sub_q <= tx_sub_q + 4'h1;
                        if (tx_sub_q == (`FMSP_TICKS_PER_BIT - 1)) begin
                            // a mode change mid-frame must not strand the count
                            if (tx_bit_q >= stop_idx) begin
                                tx_st_q <= S_IDLE;
                            end else begin
                                tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                                tx_bit_q <= tx_bit_q + 4'h1;
                            end
                        end
                    end
                end
                S_M0TX, S_M0RX: begin
                    m0_cnt_q <= m0_end ? 4'h0 : m0_cnt_q + 4'h1;
                    if (tx_st_q == S_M0RX
                        && m0_cnt_q == (`FMSP_M0_HALF - 1)) begin
                        m0_rx_q <= {rxd_s_q, m0_rx_q[7:1]};
                    end
                    if (m0_end) begin
                        tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                        tx_bit_q <= tx_bit_q + 4'h1;
                        if (tx_bit_q == 4'h7) begin
                            tx_st_q <= S_IDLE;
                        end
                    end
                end
                default: begin
                    tx_st_q <= S_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // asynchronous receiver
    // ****************************************
    localparam R_IDLE  = 2'd0;
    localparam R_START = 2'd1;
    localparam R_DATA  = 2'd2;

    reg [1:0] rx_st_q;
    reg [3:0] rx_sub_q;
    reg [3:0] rx_bit_q;
    reg [8:0] rx_sh_q;
    wire      rx_mid;
    wire      rx_last;
    wire      rx_pass;

    assign rx_mid  = rx_tick && (rx_sub_q == `FMSP_TICK_MID);
    // data bits 0..7, then ninth (9-bit) or stop (8-bit) as index 8; 9-bit stop at 9
    assign rx_last = (rx_bit_q == (mode[1] ? 4'd9 : 4'd8));
    // 8-bit mode tests the stop bit, 9-bit mode tests the ninth bit
    assign rx_pass = !ctrl_q[`FMSP_BIT_RX_DONE]
                   && (!filter_en || (mode[1] ? rx_sh_q[8] : rxd_s_q));

    always @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_st_q  <= R_IDLE;
            rx_sub_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_sh_q  <= 9'h000;
        end else begin
            case (rx_st_q)
                R_IDLE: begin
                    rx_sub_q <= 4'h0;
                    rx_bit_q <= 4'h0;
                    if (mode != 2'b00 && rx_en
                        && rxd_prev_q && !rxd_s_q) begin
                        rx_st_q <= R_START;
                    end
                end
                R_START: begin
                    if (rx_tick) begin
                        rx_sub_q <= rx_sub_q + 4'h1;
                    end
                    if (rx_mid) begin
                        // start bit is skipped; a high midpoint was a glitch
                        rx_st_q <= rxd_s_q ? R_IDLE : R_DATA;
                    end
                end
                R_DATA: begin
                    if (rx_tick) begin
                        rx_sub_q <= rx_sub_q + 4'h1;
                    end
                    if (rx_mid) begin
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_last) begin
                            rx_st_q <= R_IDLE;
                        end else if (rx_bit_q == 4'h8) begin
                            rx_sh_q[8] <= rxd_s_q;
                        end else begin
                            rx_sh_q[7:0] <= {rxd_s_q, rx_sh_q[7:1]};
                        end
                    end
                end
                default: begin
                    rx_st_q <= R_IDLE;
                end
            endcase
            if (mode == 2'b00 || !rx_en) begin
                rx_st_q <= R_IDLE;
            end
        end
    end

    // ****************************************
    // flag events
    // ****************************************
    always @* begin
        ti_set   = 1'b0;
        ri_set   = 1'b0;
        rb8_load = 1'b0;
        rb8_val  = 1'b0;
        if (tx_st_q == S_M0TX && m0_end && tx_bit_q == 4'h7) begin
            ti_set = 1'b1;
        end
        if (tx_st_q == S_ASYNC && tx_tick
            && tx_sub_q == (`FMSP_TICKS_PER_BIT - 1)
            && tx_bit_q == stop_idx - 4'h1) begin
            ti_set = 1'b1;
        end
        if (tx_st_q == S_M0RX && m0_end && tx_bit_q == 4'h7) begin
            ri_set = 1'b1;
        end
        if (rx_st_q == R_DATA && rx_mid && rx_last && rx_pass) begin
            ri_set   = 1'b1;
            rb8_load = 1'b1;
            rb8_val  = mode[1] ? rx_sh_q[8] : rxd_s_q;
        end
    end

    // ****************************************
    // register writes and reads
    // ****************************************
    always @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q    <= `FMSP_CONTROL_RESET;
            rx_buf_q  <= 8'h00;
            sfr_rdata <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= sfr_wdata;
            end
            // hardware set wins over a software clear in the same cycle
            if (ti_set) begin
                ctrl_q[`FMSP_BIT_TX_DONE] <= 1'b1;
            end
            if (ri_set) begin
                ctrl_q[`FMSP_BIT_RX_DONE] <= 1'b1;
            end
            if (rb8_load) begin
                ctrl_q[`FMSP_BIT_RX_NINTH] <= rb8_val;
                rx_buf_q <= rx_sh_q[7:0];
            end else if (ri_set) begin
                rx_buf_q <= m0_rx_q;
            end
            if (sfr_rd_en) begin
                case (sfr_addr)
                    `FMSP_ADDR_CONTROL: sfr_rdata <= ctrl_q;
                    `FMSP_ADDR_BUFFER:  sfr_rdata <= rx_buf_q;
                    default:            sfr_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule

// [test/fmsp_far_node.sv]
`timescale 1ns/100ps
module fmsp_far_node (
    // clock and line from the port
    input  wire logic clk_sys,
    input  wire logic txd_out,
    // settings from the bench
    input  wire logic rx_on,
    input  int        bit_cyc,
    input  int        nbits,
    // line towards the port
    output logic      far_rxd
);
    logic [10:0] frame_q;
    int          frame_cnt = 0;
    logic [7:0]  m0_byte;
    int          m0_idx = 8;
    int          i;
    initial far_rxd = 1'b1;
    // ****************************************
    // async capture and send
    // ****************************************
    // mid-bit sampling, so a wrong bit period corrupts the capture
    always @(negedge txd_out) begin
        if (rx_on) begin
            repeat (bit_cyc / 2) @(posedge clk_sys);
            frame_q[0] = txd_out;
            for (i = 1; i < nbits; i++) begin
                repeat (bit_cyc) @(posedge clk_sys);
                frame_q[i] = txd_out;
            end
            frame_cnt++;
        end
    end
    task automatic send(input logic [10:0] bits, input int n);
        int k;
        for (k = 0; k < n; k++) begin
            far_rxd <= bits[k];
            repeat (bit_cyc) @(posedge clk_sys);
        end
        far_rxd <= 1'b1;
    endtask
    // ****************************************
    // external shift register for mode 0
    // ****************************************
    task automatic m0_load(input logic [7:0] b);
        m0_byte = b;
        m0_idx  = 0;
        far_rxd <= b[0];
    endtask
    // next bit after the rising clock, well away from the sample point
    always @(posedge txd_out) begin
        if (m0_idx < 8) begin
            m0_idx++;
            far_rxd <= (m0_idx < 8) ? m0_byte[m0_idx] : ~m0_byte[7];
        end
    end
endmodule

// [test/fmsp_serial_port_monitor.sv]
`timescale 1ns/100ps
`include "fmsp_consts.vh"
module fmsp_serial_port_monitor (
    // clock and reset
    input wire       clk_sys,
    input wire       arst_n,
    // register port
    input wire [7:0] sfr_addr,
    input wire       sfr_wr_en,
    input wire [7:0] sfr_wdata,
    input wire       sfr_rd_en,
    input wire [7:0] sfr_rdata,
    input wire       tx_fifo_ready,
    // rate and pins
    input wire       rate_doubler,
    input wire       rxd_oe_n,
    input wire       txd_out
);
    reg  [7:0] ctl_q;
    reg  [9:0] low_q;
    wire       m0     = ctl_q[7:6] == 2'b00;
    wire       wr_ctl = sfr_wr_en && sfr_addr == `FMSP_ADDR_CONTROL;
    wire       wr_buf = sfr_wr_en && sfr_addr == `FMSP_ADDR_BUFFER;
    // shadow of control, since the checker cannot see inside
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q <= 8'h00;
            low_q <= 10'h000;
        end else begin
            if (wr_ctl) begin
                ctl_q <= sfr_wdata;
            end
            low_q <= txd_out ? 10'h000 : low_q + 10'h001;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_unmapped_read_zero: assert property (
        sfr_rd_en && sfr_addr != `FMSP_ADDR_CONTROL && sfr_addr != `FMSP_ADDR_BUFFER
        |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    a_read_data_holds: assert property (!sfr_rd_en |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    a_control_readback: assert property (
        sfr_rd_en && sfr_addr == `FMSP_ADDR_CONTROL && !sfr_wr_en
        |=> sfr_rdata[7:3] == ctl_q[7:3]) else $error("control bits read back wrong");
    a_shift_clock_low: assert property (
        m0 && $fell(txd_out) |-> !txd_out [*6] ##1 txd_out)
        else $error("shift clock low phase wrong");
    a_shift_clock_high: assert property (
        m0 && !rxd_oe_n && $rose(txd_out) |-> txd_out [*6])
        else $error("shift clock high phase wrong");
    a_drive_mode0_only: assert property (!rxd_oe_n |-> m0)
        else $error("data pin driven outside mode 0");
    a_buffer_write_starts: assert property (
        m0 && !ctl_q[4] && wr_buf && tx_fifo_ready && rxd_oe_n |-> ##[1:3] !rxd_oe_n)
        else $error("mode 0 write did not start");
    a_fixed_bit_length: assert property (
        ctl_q[7:6] == 2'b10 && !rate_doubler && $rose(txd_out) |-> low_q[5:0] == 6'h00)
        else $error("mode 2 bit length not 64");
endmodule
bind fmsp_serial_port fmsp_serial_port_monitor u_mon (
    .clk_sys(clk_sys), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_wdata(sfr_wdata), .sfr_rd_en(sfr_rd_en), .sfr_rdata(sfr_rdata),
    .tx_fifo_ready(tx_fifo_ready), .rate_doubler(rate_doubler), .rxd_oe_n(rxd_oe_n),
    .txd_out(txd_out));

// [test/fmsp_serial_port_test.sv]
`timescale 1ns/100ps
`include "fmsp_consts.vh"
module fmsp_serial_port_test;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rv;
    logic       clk_sys, arst_n, sfr_wr_en, sfr_rd_en, tx_fifo_ready, rate_doubler;
    logic       timer1_ovf, timer2_ovf, rxd_out, rxd_oe_n, txd_out, far_rxd, rx_on, rsel;
    int         bit_cyc, nbits, mismatches, cmp_count, base;
    // the data pin as a wire: port when driving, else the far node
    wire        rxd_wire = rxd_oe_n ? far_rxd : rxd_out;
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        timer1_ovf <= ~timer1_ovf;
        timer2_ovf <= timer1_ovf;
    end
    fmsp_serial_port dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .sfr_addr(sfr_addr),
        .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata), .sfr_rd_en(sfr_rd_en),
        .sfr_rdata(sfr_rdata), .tx_fifo_ready(tx_fifo_ready), .rate_doubler(rate_doubler),
        .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf), .tx_use_timer2(1'b0),
        .rx_use_timer2(rsel), .rxd_in(rxd_wire), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n),
        .txd_out(txd_out));
    fmsp_far_node u_far (.clk_sys(clk_sys), .txd_out(txd_out), .rx_on(rx_on),
        .bit_cyc(bit_cyc), .nbits(nbits), .far_rxd(far_rxd));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr_en <= 1'b1;
        @(posedge clk_sys);
        sfr_wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        sfr_addr  <= a;
        sfr_rd_en <= 1'b1;
        @(posedge clk_sys);
        sfr_rd_en <= 1'b0;
        #1;
        rv = sfr_rdata;
    endtask
    task automatic wait_frames(input int n);
        int k;
        for (k = 0; k < 20000 && u_far.frame_cnt < n; k++) begin
            @(posedge clk_sys);
        end
        if (u_far.frame_cnt < n) begin
            mismatches++;
            end_sim();
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rd(`FMSP_ADDR_CONTROL);
        chk("control reset", rv, `FMSP_CONTROL_RESET);
        rd(8'h55);
        chk("unmapped read", rv, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_mode2_tx;
        wr(`FMSP_ADDR_CONTROL, 8'h88);
        wr(`FMSP_ADDR_BUFFER, 8'ha5);
        wait_frames(1);
        chk("mode 2 frame", u_far.frame_q, {2'b11, 8'ha5, 1'b0});
        rd(`FMSP_ADDR_CONTROL);
        chk("tx done set", rv[1], 1'b1);
        wr(`FMSP_ADDR_CONTROL, 8'h80);
        rd(`FMSP_ADDR_CONTROL);
        chk("tx done cleared", rv[1], 1'b0);
        $display("test mode 2 transmit done");
    endtask
    task automatic t_fifo_fill;
        int n;
        int k;
        n = 0;
        // fill until refused, the line drains one frame every 704 cycles
        for (k = 0; k < 12 && tx_fifo_ready === 1'b1; k++) begin
            wr(`FMSP_ADDR_BUFFER, 8'h10 + k[7:0]);
            n++;
        end
        chk("fifo refuses", tx_fifo_ready, 1'b0);
        chk("fifo depth", n >= 8 && n <= 9, 1'b1);
        wait_frames(1 + n);
        chk("last queued byte", u_far.frame_q[8:1], 8'h10 + n[7:0] - 8'h01);
        chk("ninth from field", u_far.frame_q[9], 1'b0);
        $display("test fifo done");
    endtask
    task automatic t_mode1_tx;
        rate_doubler <= 1'b1;
        bit_cyc = 32;
        nbits = 10;
        base = u_far.frame_cnt + 1;
        wr(`FMSP_ADDR_CONTROL, 8'h40);
        wr(`FMSP_ADDR_BUFFER, 8'h3c);
        wait_frames(base);
        chk("mode 1 frame", u_far.frame_q[9:0], {1'b1, 8'h3c, 1'b0});
        $display("test mode 1 transmit done");
    endtask
    task automatic t_mode1_rx;
        wr(`FMSP_ADDR_CONTROL, 8'h70);
        u_far.send({2'b00, 8'h11, 1'b0}, 10);
        rd(`FMSP_ADDR_CONTROL);
        chk("bad stop dropped", rv[0], 1'b0);
        u_far.send({2'b01, 8'h5a, 1'b0}, 10);
        rd(`FMSP_ADDR_CONTROL);
        chk("rx flags", rv[2:0], 3'b101);
        rd(`FMSP_ADDR_BUFFER);
        chk("rx byte", rv, 8'h5a);
        u_far.send({2'b01, 8'h77, 1'b0}, 10);
        rd(`FMSP_ADDR_BUFFER);
        chk("frame lost while full", rv, 8'h5a);
        $display("test mode 1 receive done");
    endtask
    task automatic t_mode3_rx;
        nbits = 11;
        // receiver moves to the first timer; doubler keeps the bit at 32
        rsel <= 1'b0;
        wr(`FMSP_ADDR_CONTROL, 8'hf0);
        u_far.send({2'b10, 8'h21, 1'b0}, 11);
        rd(`FMSP_ADDR_CONTROL);
        chk("ninth 0 dropped", rv[0], 1'b0);
        u_far.send({2'b11, 8'hc3, 1'b0}, 11);
        rd(`FMSP_ADDR_CONTROL);
        chk("mode 3 flags", rv[2:0], 3'b101);
        rd(`FMSP_ADDR_BUFFER);
        chk("mode 3 byte", rv, 8'hc3);
        wr(`FMSP_ADDR_CONTROL, 8'he0);
        u_far.send({2'b11, 8'h99, 1'b0}, 11);
        rd(`FMSP_ADDR_CONTROL);
        chk("rx disabled", rv[0], 1'b0);
        $display("test mode 3 receive done");
    endtask
    task automatic t_mode0;
        logic [7:0] got;
        logic       prev;
        int         k;
        int         cnt;
        rx_on = 1'b0;
        got = 8'h00;
        prev = 1'b1;
        cnt = 0;
        wr(`FMSP_ADDR_CONTROL, 8'h00);
        wr(`FMSP_ADDR_BUFFER, 8'h96);
        for (k = 0; k < 300; k++) begin
            @(posedge clk_sys);
            #1;
            if (!prev && txd_out && !rxd_oe_n) begin
                got = {rxd_out, got[7:1]};
                cnt++;
            end
            prev = txd_out;
        end
        chk("mode 0 byte", got, 8'h96);
        chk("mode 0 clocks", cnt, 8);
        rd(`FMSP_ADDR_CONTROL);
        chk("mode 0 tx done", rv[1], 1'b1);
        u_far.m0_load(8'h4b);
        wr(`FMSP_ADDR_CONTROL, 8'h10);
        repeat (150) @(posedge clk_sys);
        rd(`FMSP_ADDR_CONTROL);
        chk("mode 0 rx done", rv[0], 1'b1);
        rd(`FMSP_ADDR_BUFFER);
        chk("mode 0 rx byte", rv, 8'h4b);
        $display("test mode 0 done");
    endtask
    initial begin
        arst_n = 1'b0;
        {sfr_addr, sfr_wdata, sfr_wr_en, sfr_rd_en} = 18'h00000;
        {rate_doubler, timer1_ovf, timer2_ovf} = 3'b000;
        rx_on = 1'b1;
        rsel = 1'b1;
        bit_cyc = 64;
        nbits = 11;
        mismatches = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset();
        t_mode2_tx();
        t_fifo_fill();
        t_mode1_tx();
        t_mode1_rx();
        t_mode3_rx();
        t_mode0();
        end_sim();
    end
endmodule
